// ==== logic/sbr_top.sv ====
// sample buffer control: scan sequencing, coding, gain lookup, host RAM access
// assumes converter, CONTROL_STATUS_REGISTER and CHANNEL_CONFIGURATION_REGISTER live outside; all inputs are on core_clk
`timescale 1ns/1ns
module sbr_top
  import sbr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [14:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [1:0] host_be,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rd_valid,
  input wire logic [15:0] channel_configuration_register,
  input wire logic csr_code_fmt,
  input wire logic [15:0] rate_div,
  input wire logic fixed_gain_x10,
  input wire logic auto_gain_en,
  input wire logic gain_wr,
  input wire logic [5:0] gain_wr_chan,
  input wire logic gain_wr_x10,
  input wire logic scan_start,
  output logic conv_req,
  output logic [5:0] conv_chan,
  output logic conv_gain_x10,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  output logic adc_ready,
  output logic scan_busy,
  output logic scan_done
);
  sbr_regs_t r_ff, nxt_r;
  sbr_ram_if ram ();
  logic push, fifo_out_valid, host_acc, host_hit, last, gain_look;
  logic [FIFO_W-1:0] push_data, fifo_out_data;
  logic [1:0] mode;
  logic [6:0] blk;
  logic [10:0] words, word_addr;
  logic [5:0] chan;
  logic [15:0] fmt, reload;

  sbr_ram u_ram (
    .core_clk(core_clk),
    .port(ram.mem)
  );

  // host access owns the RAM port; scan data waits in the FIFO meanwhile
  sbr_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(adc_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(!host_acc),
    .out_data(fifo_out_data)
  );

  always_comb begin
    mode = channel_configuration_register[CCR_MODE_LSB +: 2];
    words = sbr_buf_words(channel_configuration_register[CCR_BUF_LSB +: 5]);
    blk = sbr_blk_size(channel_configuration_register[CCR_BLK_LSB +: 6]);
    if (mode == MODE_RAND) chan = channel_configuration_register[CCR_BLK_LSB +: 6];
    else if (channel_configuration_register[CCR_ORDER_BIT]) chan = 6'(blk - 7'h01 - {1'b0, r_ff.ch});
    else chan = r_ff.ch;
    gain_look = r_ff.gain_tab[chan];
    // offset binary to two's complement is a top-bit flip
    fmt = adc_data ^ {csr_code_fmt, 15'h0000};
    word_addr = DATA_BASE_W + {1'b0, r_ff.word};
    last = (mode == MODE_RAND) || ({1'b0, r_ff.word} == words - 11'h001);
    push = (r_ff.st == ST_WAIT) && adc_valid && adc_ready;
    push_data = {r_ff.tag, fmt};
    host_acc = host_rd || host_wr;
    host_hit = sbr_in_ram(host_addr);
    reload = (rate_div == 16'h0000) ? DEF_TICKS - 16'h0001 : rate_div - 16'h0001;
  end

  // host word access; scan writes only tagged buffer words
  always_comb begin
    if (host_acc) begin
      ram.en = host_hit;
      ram.we = host_wr;
      ram.be = host_be;
      ram.addr = host_addr[RAM_AW:1];
      ram.wdata = host_wdata;
    end else begin
      ram.en = fifo_out_valid;
      ram.we = 1'b1;
      ram.be = 2'h3;
      ram.addr = fifo_out_data[FIFO_W-1 -: RAM_AW];
      ram.wdata = fifo_out_data[SAMPLE_W-1:0];
    end
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.conv_req = 1'b0;
    nxt_r.done = 1'b0;
    if (gain_wr) nxt_r.gain_tab[gain_wr_chan] = gain_wr_x10;
    nxt_r.tick = (r_ff.tick == 16'h0000) ? reload : r_ff.tick - 16'h0001;
    nxt_r.rd_p1 = host_rd;
    nxt_r.hit_p1 = host_hit;
    nxt_r.rd_valid = r_ff.rd_p1;
    // unmapped reads answer zero
    if (r_ff.rd_p1) nxt_r.rdata = r_ff.hit_p1 ? ram.rdata : 16'h0000;
    case (r_ff.st)
      ST_IDLE: begin
        if (mode == MODE_AUTO || scan_start) begin
          nxt_r.st = ST_SCAN;
          nxt_r.word = '0;
          nxt_r.ch = '0;
          nxt_r.busy = 1'b1;
        end
      end
      ST_SCAN: begin
        if (r_ff.tick == 16'h0000) begin
          nxt_r.conv_req = 1'b1;
          nxt_r.conv_chan = chan;
          nxt_r.conv_gain_x10 = auto_gain_en ? gain_look : fixed_gain_x10;
          // random access lands at first word
          nxt_r.tag = (mode == MODE_RAND) ? DATA_BASE_W : word_addr;
          nxt_r.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (push) begin
          if (last) begin
            nxt_r.done = 1'b1;
            nxt_r.word = '0;
            nxt_r.ch = '0;
            nxt_r.st = (mode == MODE_AUTO) ? ST_SCAN : ST_IDLE;
            nxt_r.busy = mode == MODE_AUTO;
          end else begin
            nxt_r.word = r_ff.word + 10'h001;
            nxt_r.ch = ({1'b0, r_ff.ch} == blk - 7'h01) ? 6'h00 : r_ff.ch + 6'h01;
            nxt_r.st = ST_SCAN;
          end
        end
      end
      default: nxt_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) r_ff <= '{st: ST_IDLE, default: '0};
    else r_ff <= nxt_r;
  end

  assign host_rdata = r_ff.rdata;
  assign host_rd_valid = r_ff.rd_valid;
  assign conv_req = r_ff.conv_req;
  assign conv_chan = r_ff.conv_chan;
  assign conv_gain_x10 = r_ff.conv_gain_x10;
  assign scan_busy = r_ff.busy;
  assign scan_done = r_ff.done;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_rd_answer;
    host_rd |-> ##2 host_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

  property p_scan_in_buf;
    (ram.en && ram.we && !host_acc) |-> (ram.addr >= DATA_BASE_W) && (ram.addr < DATA_BASE_W + words);
  endproperty
  a_scan_in_buf: assert property (p_scan_in_buf) else $error("scan write outside buffer");

  property p_offset_bin;
    (push && !csr_code_fmt) |-> push_data[15:0] == adc_data;
  endproperty
  a_offset_bin: assert property (p_offset_bin) else $error("offset binary altered");

  property p_twos;
    (push && csr_code_fmt) |-> (push_data[15] != adc_data[15]) && (push_data[14:0] == adc_data[14:0]);
  endproperty
  a_twos: assert property (p_twos) else $error("two's complement wrong");

  property p_gain_auto;
    (r_ff.st == ST_SCAN && r_ff.tick == 16'h0000 && auto_gain_en) |=> conv_gain_x10 == $past(gain_look);
  endproperty
  a_gain_auto: assert property (p_gain_auto) else $error("gain lookup wrong");

  property p_rand_addr;
    (r_ff.st == ST_SCAN && r_ff.tick == 16'h0000 && mode == MODE_RAND) |=> r_ff.tag == DATA_BASE_W;
  endproperty
  a_rand_addr: assert property (p_rand_addr) else $error("random word misplaced");

  property p_ascend;
    (r_ff.st == ST_SCAN && r_ff.tick == 16'h0000 && mode != MODE_RAND) |=> r_ff.tag == $past(word_addr);
  endproperty
  a_ascend: assert property (p_ascend) else $error("word address wrong");

  property p_rate;
    (conv_req && rate_div == 16'h0000) |=> !conv_req [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("conversions too close");

  property p_restart;
    (scan_done && mode == MODE_AUTO) |-> r_ff.word == 10'h000 && r_ff.st == ST_SCAN;
  endproperty
  a_restart: assert property (p_restart) else $error("scan did not restart");

  property p_rd_source;
    host_rd_valid |-> $past(host_rd, 2);
  endproperty
  a_rd_source: assert property (p_rd_source) else $error("read answer without read");

  property p_rdata_hold;
    !host_rd_valid |-> $stable(host_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_unmapped_zero;
    (host_rd && !host_hit) |-> ##2 host_rdata == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_no_scratch;
    (ram.en && ram.we && !host_acc) |-> ram.addr < SCR_LO[RAM_AW:1];
  endproperty
  a_no_scratch: assert property (p_no_scratch) else $error("scan wrote scratch");

  property p_req_pulse;
    conv_req |=> !conv_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");

  property p_req_waits;
    conv_req |-> r_ff.st == ST_WAIT;
  endproperty
  a_req_waits: assert property (p_req_waits) else $error("request without wait");

  property p_hold_result;
    (adc_valid && r_ff.st == ST_WAIT && !adc_ready) |=> r_ff.st == ST_WAIT;
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result dropped while full");

  property p_done_pulse;
    scan_done |-> $past(push) && $past(last);
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done without last word");

  property p_tick_reload;
    (r_ff.tick == 16'h0000) |=> r_ff.tick == $past(reload);
  endproperty
  a_tick_reload: assert property (p_tick_reload) else $error("rate divider reload wrong");

  property p_idle_no_req;
    (r_ff.st == ST_IDLE) |-> !conv_req;
  endproperty
  a_idle_no_req: assert property (p_idle_no_req) else $error("request while idle");

  property p_blk_wrap;
    (push && !last && ({1'b0, r_ff.ch} == blk - 7'h01)) |=> r_ff.ch == 6'h00;
  endproperty
  a_blk_wrap: assert property (p_blk_wrap) else $error("block did not wrap");

  property p_word_step;
    (push && !last) |=> r_ff.word == $past(r_ff.word) + 10'h001;
  endproperty
  a_word_step: assert property (p_word_step) else $error("word did not advance");

  property p_fixed_gain;
    (r_ff.st == ST_SCAN && r_ff.tick == 16'h0000 && !auto_gain_en) |=> conv_gain_x10 == $past(fixed_gain_x10);
  endproperty
  a_fixed_gain: assert property (p_fixed_gain) else $error("fixed gain wrong");

  property p_rand_chan;
    (r_ff.st == ST_SCAN && r_ff.tick == 16'h0000 && mode == MODE_RAND) |=> conv_chan == $past(channel_configuration_register[CCR_BLK_LSB +: 6]);
  endproperty
  a_rand_chan: assert property (p_rand_chan) else $error("random channel wrong");

  property p_asc_chan;
    (r_ff.st == ST_SCAN && r_ff.tick == 16'h0000 && mode != MODE_RAND && !channel_configuration_register[CCR_ORDER_BIT])
      |=> conv_chan == $past(r_ff.ch);
  endproperty
  a_asc_chan: assert property (p_asc_chan) else $error("ascending channel wrong");

  property p_busy_idle;
    !scan_busy |-> r_ff.st == ST_IDLE;
  endproperty
  a_busy_idle: assert property (p_busy_idle) else $error("not busy but scanning");

  property p_restart_word;
    (push && last) |=> r_ff.word == 10'h000 && r_ff.ch == 6'h00;
  endproperty
  a_restart_word: assert property (p_restart_word) else $error("scan end did not rewind");
endmodule : sbr_top

// ==== logic/sbr_pkg.sv ====
// constants, types and decode functions of the sample buffer RAM block
// assumes one 25 MHz clock; control and status registers are kept outside this block
package sbr_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DEF_RATE_HZ = 100_000;
  localparam logic [15:0] DEF_TICKS = 16'(CLK_HZ / DEF_RATE_HZ);
  localparam logic [14:0] DATA_LO = 15'h0080;
  localparam logic [14:0] DATA_HI = 15'h087E;
  localparam logic [14:0] SCR_LO = 15'h0880;
  localparam logic [14:0] SCR_HI = 15'h0FFE;
  localparam logic [10:0] DATA_BASE_W = DATA_LO[11:1];
  localparam int CSR_FMT_BIT = 14;
  localparam int CCR_BUF_LSB = 11;
  localparam int CCR_MODE_LSB = 6;
  localparam int CCR_ORDER_BIT = 9;
  localparam int CCR_BLK_LSB = 0;
  localparam int RAM_AW = 11;
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = RAM_AW + SAMPLE_W;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_RAND = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_WAIT = 3'b100
  } sbr_state_t;

  typedef struct packed {
    sbr_state_t st;
    logic [9:0] word;
    logic [5:0] ch;
    logic [15:0] tick;
    logic [RAM_AW-1:0] tag;
    logic [63:0] gain_tab;
    logic conv_req;
    logic [5:0] conv_chan;
    logic conv_gain_x10;
    logic rd_p1;
    logic hit_p1;
    logic rd_valid;
    logic [15:0] rdata;
    logic busy;
    logic done;
  } sbr_regs_t;

  function automatic logic sbr_in_ram(input logic [14:0] a);
    return (a >= DATA_LO) && (a <= SCR_HI);
  endfunction : sbr_in_ram

  // field 0 reads as the smallest buffer; 3 gives 64 words as after reset
  function automatic logic [10:0] sbr_buf_words(input logic [4:0] f);
    logic [2:0] sh;
    sh = (f[2:0] == 3'h0) ? 3'h0 : f[2:0] - 3'h1;
    return 11'h010 << sh;
  endfunction : sbr_buf_words

  function automatic logic [6:0] sbr_blk_size(input logic [5:0] f);
    case (f)
      6'h01: return 7'h01;
      6'h08: return 7'h08;
      6'h10: return 7'h10;
      6'h20: return 7'h20;
      default: return 7'h40;
    endcase
  endfunction : sbr_blk_size
endpackage : sbr_pkg

// ==== logic/sbr_ram_if.sv ====
// single-port word port between the buffer control and its RAM
// assumes both ends run on core_clk
`timescale 1ns/1ns
interface sbr_ram_if;
  import sbr_pkg::*;
  logic en;
  logic we;
  logic [1:0] be;
  logic [RAM_AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output en, output we, output be, output addr, output wdata, input rdata);
  modport mem (input en, input we, input be, input addr, input wdata, output rdata);
endinterface : sbr_ram_if

// ==== logic/sbr_fifo.sv ====
// sample FIFO between converter and RAM, registered ready on the fill side
// assumes one clock; drain side may stall for any time
`timescale 1ns/1ns
module sbr_fifo #(
  parameter int W = 27,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rp_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) nxt_cnt = cnt_ff + CW'(1);
    else if (pop && !push) nxt_cnt = cnt_ff - CW'(1);
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wp_ff] <= in_data;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + AW'(1);
      if (pop) rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + AW'(1);
      cnt_ff <= nxt_cnt;
      in_ready <= nxt_cnt != CW'(DEPTH);
    end
  end
endmodule : sbr_fifo

// ==== logic/sbr_ram.sv ====
// 2048 x 16 on-board RAM with byte lanes and registered read data
// assumes one access per cycle from the controller
`timescale 1ns/1ns
module sbr_ram
  import sbr_pkg::*;
(
  input wire logic core_clk,
  sbr_ram_if.mem port
);
  logic [15:0] mem [2**RAM_AW];
  always_ff @(posedge core_clk) begin
    if (port.en) begin
      if (port.we) begin
        if (port.be[0]) mem[port.addr][7:0] <= port.wdata[7:0];
        if (port.be[1]) mem[port.addr][15:8] <= port.wdata[15:8];
      end else begin
        port.rdata <= mem[port.addr];
      end
    end
  end
endmodule : sbr_ram

// ==== testbench/sbr_adc_model.sv ====
// converter stand-in: one result per conv_req, prompt or slow
// assumes conv_req is a registered pulse on core_clk
`timescale 1ns/1ns
module sbr_adc_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic conv_req,
  input wire logic [5:0] conv_chan,
  input wire logic [9:0] salt,
  input wire logic slow,
  input wire logic adc_ready,
  output logic adc_valid,
  output logic [15:0] adc_data
);
  logic pend_ff = 1'b0;
  logic [2:0] wait_ff = 3'h0;
  logic [5:0] chan_ff = 6'h00;
  initial adc_valid = 1'b0;
  initial adc_data = 16'hA5A5;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      adc_valid <= 1'b0;
      pend_ff <= 1'b0;
    end else if (adc_valid && adc_ready) begin
      adc_valid <= 1'b0;
      // released lines must not keep showing the old sample
      adc_data <= ~adc_data;
    end else if (conv_req) begin
      pend_ff <= 1'b1;
      wait_ff <= slow ? 3'h5 : 3'h0;
      chan_ff <= conv_chan;
    end else if (pend_ff && wait_ff == 3'h0) begin
      pend_ff <= 1'b0;
      adc_valid <= 1'b1;
      adc_data <= {salt, chan_ff};
    end else if (pend_ff) begin
      wait_ff <= wait_ff - 3'h1;
    end
  end
endmodule : sbr_adc_model

// ==== testbench/testbench.sv ====
// self-checking bench of the sample buffer block
// assumes the converter model on the far side; reads checked through a queue
`timescale 1ns/1ns
module testbench;
  import sbr_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, host_rd = 1'b0, host_wr = 1'b0, csr_code_fmt = 1'b0;
  logic fixed_gain_x10 = 1'b0, auto_gain_en = 1'b0, gain_wr = 1'b0, gain_wr_x10 = 1'b0;
  logic scan_start = 1'b0, slow = 1'b0, host_rd_valid, conv_req, conv_gain_x10, adc_valid;
  logic adc_ready, scan_busy, scan_done;
  logic [14:0] host_addr = 15'h0000;
  logic [1:0] host_be = 2'h3;
  logic [15:0] host_wdata = 16'h0000, channel_configuration_register = 16'h0048, rate_div = 16'h0003, host_rdata, adc_data;
  logic [5:0] gain_wr_chan = 6'h00, conv_chan;
  logic [9:0] salt = 10'h000;
  logic tab [64];
  logic [15:0] exp_q [$];
  logic [14:0] ad [4] = '{15'h0080, 15'h087E, 15'h0880, 15'h0FFE};
  logic [15:0] d;
  int err_total = 0, num_checks = 0, cyc = 0, n;
  int seed = 32'h49E74647;
  int last_req = -1000;
  always #20 core_clk = ~core_clk;
  sbr_top dut (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rd_valid(host_rd_valid), .channel_configuration_register(channel_configuration_register), .csr_code_fmt(csr_code_fmt), .rate_div(rate_div),
    .fixed_gain_x10(fixed_gain_x10), .auto_gain_en(auto_gain_en), .gain_wr(gain_wr),
    .gain_wr_chan(gain_wr_chan), .gain_wr_x10(gain_wr_x10), .scan_start(scan_start),
    .conv_req(conv_req), .conv_chan(conv_chan), .conv_gain_x10(conv_gain_x10), .adc_valid(adc_valid),
    .adc_data(adc_data), .adc_ready(adc_ready), .scan_busy(scan_busy), .scan_done(scan_done));
  sbr_adc_model adc (.core_clk(core_clk), .rst_n(rst_n), .conv_req(conv_req), .conv_chan(conv_chan),
    .salt(salt), .slow(slow), .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_data(adc_data));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [14:0] a, input logic [15:0] wd, input logic [1:0] be,
    input logic [15:0] e);
    @(posedge core_clk);
    host_addr <= a;
    host_wr <= wr;
    host_rd <= !wr;
    host_wdata <= wd;
    host_be <= be;
    if (!wr) exp_q.push_back(e);
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
  endtask : acc
  task automatic run_scan(input logic [15:0] cfg, input logic fmt, input logic ag, input int words,
    input int blk);
    logic [15:0] mark;
    int c;
    mark = 16'($random(seed));
    acc(1'b1, DATA_LO + 15'(2 * words), mark, 2'h3, 16'h0000);
    channel_configuration_register <= cfg;
    csr_code_fmt <= fmt;
    auto_gain_en <= ag;
    fixed_gain_x10 <= 1'($random(seed));
    salt <= 10'($random(seed));
    slow <= fmt;
    @(posedge core_clk);
    scan_start <= 1'b1;
    @(posedge core_clk);
    scan_start <= 1'b0;
    @(posedge core_clk);
    chk(16'(scan_busy), 16'h0001);
    for (c = 0; c < 6000 && scan_done !== 1'b1; c++) @(posedge core_clk);
    chk(16'(c < 6000), 16'h0001);
    chk(16'(scan_busy), 16'(cfg[7:6] == 2'h0));
    repeat (3) @(posedge core_clk);
    for (n = 0; n < words; n++) begin
      c = cfg[7] ? int'(cfg[5:0]) : (cfg[9] ? blk - 1 - n % blk : n % blk);
      // expected word from channel and format
      acc(1'b0, DATA_LO + 15'(2 * n), 16'h0000, 2'h3, {salt, 6'(c)} ^ {fmt, 15'h0000});
    end
    // word past the buffer keeps host data
    acc(1'b0, DATA_LO + 15'(2 * words), 16'h0000, 2'h3, mark);
    repeat (3) @(posedge core_clk);
    $display("test scan %h done", cfg);
  endtask : run_scan
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  always @(posedge core_clk) begin
    if (host_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else chk(host_rdata, exp_q.pop_front());
    end
    if (conv_req === 1'b1) begin
      chk(16'(conv_gain_x10), 16'(auto_gain_en ? tab[conv_chan] : fixed_gain_x10));
      chk(16'(cyc - last_req >= (rate_div == 16'h0000 ? int'(DEF_TICKS) : int'(rate_div))), 16'h0001);
      last_req = cyc;
    end
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rate_div <= 16'(2 + ($random(seed) & 7));
    // gain table loaded before any scan
    for (n = 0; n < 64; n++) begin
      @(posedge core_clk);
      tab[n] = 1'($random(seed));
      gain_wr <= 1'b1;
      gain_wr_chan <= 6'(n);
      gain_wr_x10 <= tab[n];
    end
    @(posedge core_clk);
    gain_wr <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      acc(1'b1, ad[i], d, 2'h3, 16'h0000);
      acc(1'b0, ad[i], 16'h0000, 2'h3, d);
    end
    acc(1'b1, 15'h0880, 16'hFFFF, 2'h3, 16'h0000);
    acc(1'b1, 15'h0880, 16'h1234, 2'h2, 16'h0000);
    acc(1'b0, 15'h0880, 16'h0000, 2'h3, 16'h12FF);
    acc(1'b1, 15'h1000, 16'hFFFF, 2'h3, 16'h0000);
    acc(1'b0, 15'h1000, 16'h0000, 2'h3, 16'h0000);
    acc(1'b0, 15'h0000, 16'h0000, 2'h3, 16'h0000);
    repeat (3) @(posedge core_clk);
    $display("test memory done");
    // first scan at the default rate
    rate_div <= 16'h0000;
    run_scan(16'h0048, 1'b0, 1'b0, 16, 8);
    rate_div <= 16'(2 + ($random(seed) & 7));
    run_scan(16'h0248, 1'b1, 1'b1, 16, 8);
    run_scan(16'h1041, 1'b0, 1'b1, 32, 1);
    run_scan(16'h0085, 1'b1, 1'b0, 1, 64);
    // continuous scanning goes last since it never stops
    run_scan(16'h1800, 1'b0, 1'b1, 64, 64);
    test_done();
  end
endmodule : testbench
